// [rtl/sfc_pkg.sv]
package sfc_pkg;

    // system clock
    localparam int CLK_MHZ = 125;

    // power-on reset windows, microseconds
    localparam int T_POR_FAST_MIN_US = 3000;
    localparam int T_POR_FAST_MAX_US = 9000;
    localparam int T_POR_STD_MIN_US  = 50000;
    localparam int T_POR_STD_MAX_US  = 200000;

    // hold time aims at the middle of each window
    localparam logic [23:0] POR_FAST_CYCLES =
        24'(((T_POR_FAST_MIN_US + T_POR_FAST_MAX_US) / 2) * CLK_MHZ);
    localparam logic [23:0] POR_STD_CYCLES =
        24'(((T_POR_STD_MIN_US + T_POR_STD_MAX_US) / 2) * CLK_MHZ);

    // error restart time-out, longest time, rounded down
    localparam int T_RESTART_MAX_US = 230;
    localparam logic [23:0] RESTART_CYCLES =
        24'(T_RESTART_MAX_US * CLK_MHZ);

    // least low time of a reconfiguration request (kept by the far side)
    localparam int T_RECONFIG_MIN_NS = 500;

    // serial clock limits and divider (125 / 4 = 31.25 MHz)
    localparam int SCLK_MIN_MHZ = 20;
    localparam int SCLK_TYP_MHZ = 30;
    localparam int SCLK_MAX_MHZ = 40;
    localparam int SCLK_DIV     = (CLK_MHZ + SCLK_MAX_MHZ - 1) / SCLK_MAX_MHZ;
    localparam logic [1:0] SCLK_PHASE_LAST = 2'(SCLK_DIV - 1);

    // internal initialization oscillator, about 10 MHz
    localparam int INIT_OSC_MHZ = 10;
    localparam logic [3:0] INIT_OSC_DIV =
        4'((CLK_MHZ + INIT_OSC_MHZ - 1) / INIT_OSC_MHZ);
    localparam logic [23:0] INIT_CYCLES = 24'hC71;

    // flash read sequence
    localparam logic [7:0]  FLASH_READ_CMD  = 8'h03;
    localparam logic [23:0] FLASH_START_ADR = 24'h000000;
    localparam logic [31:0] CMD_BITS        = 32'h00000020;

    // position of the init-done enable bit in the first frame
    localparam logic [31:0] INIT_DONE_OPT_POS = 32'h00000000;

    // scheme_select codes that pick the fast power-on hold
    localparam logic [3:0] SCHEME_FAST_A = 4'h4;
    localparam logic [3:0] SCHEME_FAST_B = 4'hD;

    // bit positions inside the synchronised pin vector
    localparam int PIN_RECONFIG = 0;
    localparam int PIN_STATUS   = 1;
    localparam int PIN_LOAD     = 2;
    localparam int PIN_USERCLK  = 3;
    localparam int PIN_DATA     = 4;
    localparam int PIN_SCHEME   = 5;
    localparam int PIN_WIDTH    = 9;

    typedef enum logic [2:0] {
        ST_POR,
        ST_RESET,
        ST_CMD,
        ST_DATA,
        ST_WAIT_DONE,
        ST_INIT,
        ST_USER,
        ST_ERROR
    } sfc_state_type;

endpackage

// [rtl/sfc_pin_sync.sv]
`timescale 1ns/1ps
module sfc_pin_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             i_clk_sys,
    input  wire logic             i_reset_n,
    input  wire logic [WIDTH-1:0] i_pins,
    output logic      [WIDTH-1:0] o_level,
    output logic      [WIDTH-1:0] o_rise
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] level;
        logic [WIDTH-1:0] last;
    } sfc_sync_type;

    sfc_sync_type r;
    sfc_sync_type n;

    // meta is read only by level; edges come from level and last
    always_comb begin
        n       = r;
        n.meta  = i_pins;
        n.level = r.meta;
        n.last  = r.level;
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign o_level = r.level;
    assign o_rise  = r.level & ~r.last;

endmodule // sfc_pin_sync

// [rtl/sfc_config_master.sv]
`timescale 1ns/1ps
module sfc_config_master
    import sfc_pkg::*;
#(
    parameter logic [23:0] POR_FAST_HOLD = POR_FAST_CYCLES,
    parameter logic [23:0] POR_STD_HOLD  = POR_STD_CYCLES,
    parameter logic [23:0] RESTART_HOLD  = RESTART_CYCLES
) (
    input  wire logic        i_clk_sys,
    input  wire logic        i_reset_n,
    input  wire logic [3:0]  i_scheme_select,
    input  wire logic        i_reconfig_req_n,
    input  wire logic        i_status_line,
    output logic             o_status_line_out,
    output logic             o_status_line_oe,
    input  wire logic        i_load_complete,
    output logic             o_load_complete_out,
    output logic             o_load_complete_oe,
    input  wire logic        i_config_serial_clock,
    output logic             o_config_serial_clock_out,
    output logic             o_config_serial_clock_oe,
    input  wire logic        i_select_output_low,
    output logic             o_select_output_low_out,
    output logic             o_select_output_low_oe,
    input  wire logic        i_serial_command_output,
    output logic             o_serial_command_output_out,
    output logic             o_serial_command_output_oe,
    input  wire logic        i_flash_data,
    input  wire logic        i_user_startup_clock,
    input  wire logic        i_user_clock_en,
    input  wire logic        i_auto_restart_en,
    input  wire logic        i_frame_error,
    input  wire logic [31:0] i_bitstream_bits,
    output logic             o_init_done_out,
    output logic             o_init_done_oe,
    output logic [7:0]       o_cfg_data,
    output logic             o_cfg_data_valid,
    output logic             o_core_reset_n,
    output logic             o_user_io_tristate,
    output logic             o_weak_pullup_en,
    output logic             o_user_mode,
    output logic [2:0]       o_stage
);

    typedef struct packed {
        sfc_state_type state;
        logic          scheme_fast;
        logic [23:0]   timer;
        logic [1:0]    phase;
        logic          sclk;
        logic          sel_n;
        logic [31:0]   shift;
        logic [31:0]   bit_cnt;
        logic [7:0]    byte_sh;
        logic [7:0]    data_out;
        logic          data_vld;
        logic [3:0]    osc_div;
        logic          init_done_en;
    } sfc_ctrl_type;

    sfc_ctrl_type r;
    sfc_ctrl_type r_nxt;

    logic [PIN_WIDTH-1:0] pin_lvl;
    logic [PIN_WIDTH-1:0] pin_rise;
    logic                 reconfig_s;
    logic                 status_s;
    logic                 load_s;
    logic                 data_s;
    logic                 user_tick;
    logic [3:0]           scheme_s;
    logic                 fall;
    logic                 osc_tick;
    logic                 init_tick;

    function automatic logic is_fast_scheme(input logic [3:0] code);
        return (code == SCHEME_FAST_A) || (code == SCHEME_FAST_B);
    endfunction

    function automatic logic link_active(input sfc_state_type st);
        return (st == ST_CMD) || (st == ST_DATA);
    endfunction

    // scheme, flash data, startup clock, load, status and request pins pass two flops before use
    sfc_pin_sync #(
        .WIDTH (PIN_WIDTH)
    ) u_pin_sync (
        .i_clk_sys (i_clk_sys),
        .i_reset_n (i_reset_n),
        .i_pins    ({i_scheme_select, i_flash_data, i_user_startup_clock,
                     i_load_complete, i_status_line, i_reconfig_req_n}),
        .o_level   (pin_lvl),
        .o_rise    (pin_rise)
    );

    assign reconfig_s = pin_lvl[PIN_RECONFIG];
    assign status_s   = pin_lvl[PIN_STATUS];
    assign load_s     = pin_lvl[PIN_LOAD];
    assign data_s     = pin_lvl[PIN_DATA];
    assign user_tick  = pin_rise[PIN_USERCLK];
    assign scheme_s   = pin_lvl[PIN_SCHEME +: 4];

    // falling edge of the serial clock is the end of the last phase
    assign fall      = link_active(r.state) && (r.phase == SCLK_PHASE_LAST);
    assign osc_tick  = (r.osc_div == INIT_OSC_DIV - 4'h1);
    assign init_tick = i_user_clock_en ? user_tick : osc_tick;

    always_comb begin
        r_nxt          = r;
        r_nxt.data_vld = 1'b0;

        // clock divider runs only while the flash is being read
        if (link_active(r.state)) begin
            r_nxt.phase = (r.phase == SCLK_PHASE_LAST) ? 2'h0 : r.phase + 2'h1;
            r_nxt.sclk  = r_nxt.phase[1];
        end

        unique case (r.state)
            ST_POR: begin
                // straps are re-read every cycle of the hold
                r_nxt.scheme_fast = is_fast_scheme(scheme_s);
                r_nxt.timer       = r.timer + 24'h1;
                if (r.scheme_fast && r.timer >= POR_FAST_HOLD - 24'h1) begin
                    r_nxt.state = ST_RESET;
                end else if (!r.scheme_fast &&
                             r.timer >= POR_STD_HOLD - 24'h1) begin
                    r_nxt.state = ST_RESET;
                end
            end
            ST_RESET: begin
                r_nxt.timer        = 24'h0;
                r_nxt.init_done_en = 1'b0;
                r_nxt.sel_n        = 1'b1;
                if (reconfig_s && status_s) begin
                    r_nxt.state   = ST_CMD;
                    r_nxt.sel_n   = 1'b0;
                    r_nxt.shift   = {FLASH_READ_CMD, FLASH_START_ADR};
                    r_nxt.bit_cnt = 32'h0;
                    r_nxt.phase   = 2'h0;
                    r_nxt.sclk    = 1'b0;
                end
            end
            ST_CMD: begin
                if (fall) begin
                    r_nxt.shift = {r.shift[30:0], 1'b0};
                    if (r.bit_cnt == CMD_BITS - 32'h1) begin
                        r_nxt.bit_cnt = 32'h0;
                        r_nxt.state   = ST_DATA;
                    end else begin
                        r_nxt.bit_cnt = r.bit_cnt + 32'h1;
                    end
                end
            end
            ST_DATA: begin
                if (fall) begin
                    r_nxt.byte_sh = {r.byte_sh[6:0], data_s};
                    if (r.bit_cnt == INIT_DONE_OPT_POS && data_s) begin
                        r_nxt.init_done_en = 1'b1;
                    end
                    if (r.bit_cnt[2:0] == 3'h7) begin
                        r_nxt.data_out = {r.byte_sh[6:0], data_s};
                        r_nxt.data_vld = 1'b1;
                    end
                    if (r.bit_cnt >= i_bitstream_bits - 32'h1) begin
                        r_nxt.state = ST_WAIT_DONE;
                        r_nxt.sel_n = 1'b1;
                        r_nxt.phase = 2'h0;
                        r_nxt.sclk  = 1'b0;
                    end else begin
                        r_nxt.bit_cnt = r.bit_cnt + 32'h1;
                    end
                end
            end
            ST_WAIT_DONE: begin
                r_nxt.timer   = 24'h0;
                r_nxt.osc_div = 4'h0;
                if (load_s) begin
                    r_nxt.state = ST_INIT;
                end
            end
            ST_INIT: begin
                r_nxt.osc_div = osc_tick ? 4'h0 : r.osc_div + 4'h1;
                if (init_tick) begin
                    r_nxt.timer = r.timer + 24'h1;
                    if (r.timer == INIT_CYCLES - 24'h1) begin
                        r_nxt.state = ST_USER;
                    end
                end
            end
            ST_USER: begin
                r_nxt.timer = 24'h0;
            end
            ST_ERROR: begin
                // select held high across the time-out resets the flash
                r_nxt.sel_n = 1'b1;
                if (i_auto_restart_en) begin
                    r_nxt.timer = r.timer + 24'h1;
                    if (r.timer >= RESTART_HOLD - 24'h1) begin
                        r_nxt.state = ST_RESET;
                    end
                end
            end
        endcase

        if (link_active(r.state) && i_frame_error) begin
            r_nxt.state = ST_ERROR;
            r_nxt.timer = 24'h0;
            r_nxt.sel_n = 1'b1;
            r_nxt.phase = 2'h0;
            r_nxt.sclk  = 1'b0;
        end

        // a reconfiguration request overrides every stage but power-on
        if (r.state != ST_POR && !reconfig_s) begin
            r_nxt.state = ST_RESET;
            r_nxt.timer = 24'h0;
            r_nxt.sel_n = 1'b1;
            r_nxt.phase = 2'h0;
            r_nxt.sclk  = 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            r              <= '0;
            r.state        <= ST_POR;
            r.sel_n        <= 1'b1;
        end else begin
            r <= r_nxt;
        end
    end

    // open-drain lines only ever pull low
    assign o_status_line_out = 1'b0;
    assign o_status_line_oe  = (r.state == ST_POR) ||
                               (r.state == ST_ERROR) ||
                               (r.state == ST_RESET && !reconfig_s);

    assign o_load_complete_out = 1'b0;
    assign o_load_complete_oe  = (r.state == ST_POR) ||
                                 (r.state == ST_RESET) ||
                                 (r.state == ST_CMD) ||
                                 (r.state == ST_DATA) ||
                                 (r.state == ST_ERROR);

    // flash pins drive only while reading or resetting the flash
    assign o_config_serial_clock_out   = r.sclk;
    assign o_config_serial_clock_oe    = link_active(r.state) ||
                                         (r.state == ST_ERROR);
    assign o_select_output_low_out     = r.sel_n;
    assign o_select_output_low_oe      = link_active(r.state) ||
                                         (r.state == ST_ERROR);
    assign o_serial_command_output_out = r.shift[31];
    assign o_serial_command_output_oe  = link_active(r.state);

    assign o_init_done_out = 1'b0;
    assign o_init_done_oe  = r.init_done_en && (r.state != ST_USER);

    assign o_cfg_data       = r.data_out;
    assign o_cfg_data_valid = r.data_vld;

    assign o_core_reset_n     = (r.state == ST_USER);
    assign o_user_io_tristate = (r.state != ST_USER);
    assign o_weak_pullup_en   = (r.state != ST_POR) &&
                                (r.state != ST_USER);
    assign o_user_mode        = (r.state == ST_USER);
    assign o_stage            = r.state;

endmodule // sfc_config_master

// [dv/sfc_flash_model.sv]
`timescale 1ns/1ps
module sfc_flash_model (
    input  wire logic        i_sclk,
    input  wire logic        i_sel_n,
    input  wire logic        i_cmd,
    input  wire logic [31:0] i_pattern,
    output logic             o_data,
    output logic [31:0]      o_cmd_seen
);
    int   bit_cnt = 0;
    int   out_idx = 0;
    logic data_bit = 1'h0;
    initial o_cmd_seen = 32'h0;
    always @(posedge i_sclk or posedge i_sel_n) begin
        if (i_sel_n) begin
            bit_cnt <= 0;
        end else if (bit_cnt < 32) begin
            o_cmd_seen <= {o_cmd_seen[30:0], i_cmd};
            bit_cnt <= bit_cnt + 1;
        end
    end
    always @(negedge i_sclk or posedge i_sel_n) begin
        if (i_sel_n) begin
            out_idx <= 0;
        end else if (bit_cnt == 32) begin
            data_bit <= i_pattern[31 - out_idx];
            out_idx <= (out_idx + 1) % 32;
        end
    end
    // released output: the weak pull-up holds the line high
    assign o_data = i_sel_n ? 1'h1 : data_bit;
endmodule // sfc_flash_model

// [dv/sfc_assertions.sv]
`timescale 1ns/1ps
module sfc_checker
    import sfc_pkg::*;
#(
    parameter logic [23:0] RESTART_HOLD = RESTART_CYCLES
) (
    input wire logic       i_clk_sys,
    input wire logic       i_reset_n,
    input wire logic       i_reconfig_req_n,
    input wire logic       i_status_line,
    input wire logic       i_load_complete,
    input wire logic       i_auto_restart_en,
    input wire logic       i_user_clock_en,
    input wire logic       o_status_line_oe,
    input wire logic       o_load_complete_oe,
    input wire logic       o_config_serial_clock_out,
    input wire logic       o_config_serial_clock_oe,
    input wire logic       o_select_output_low_out,
    input wire logic       o_select_output_low_oe,
    input wire logic       o_serial_command_output_out,
    input wire logic       o_serial_command_output_oe,
    input wire logic       o_init_done_oe,
    input wire logic       o_core_reset_n,
    input wire logic       o_user_io_tristate,
    input wire logic       o_weak_pullup_en,
    input wire logic       o_user_mode,
    input wire logic [2:0] o_stage
);
    localparam int RWIN = int'(RESTART_HOLD) + 8;
    localparam int TLO  = 3184 * 13;
    localparam int THI  = 3186 * 13;
    logic [16:0] init_cnt_r;
    logic [15:0] err_cnt_r;
    // cycles spent in the error stage with auto restart on
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            err_cnt_r <= 16'h0;
        end else if (o_stage == 3'h7 && i_auto_restart_en) begin
            err_cnt_r <= err_cnt_r + 16'h1;
        end else begin
            err_cnt_r <= 16'h0;
        end
    end
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n)
            init_cnt_r <= 17'h0;
        else
            init_cnt_r <= (o_stage == 3'h5) ? init_cnt_r + 17'h1 : 17'h0;
    end
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_reset_n);
    AST_POR_LINES: assert property (
        o_stage == 3'h0 |-> o_status_line_oe && o_load_complete_oe
        && o_user_io_tristate && !o_weak_pullup_en && !o_core_reset_n)
        else $error("power-on outputs wrong");
    AST_SEL_CFG: assert property (
        o_stage inside {3'h2, 3'h3} |-> !o_select_output_low_out
        && o_select_output_low_oe && o_serial_command_output_oe)
        else $error("flash not selected");
    AST_CMD_EDGE: assert property (
        o_stage == 3'h2 && $past(o_stage) == 3'h2
        && $changed(o_serial_command_output_out)
        |-> $fell(o_config_serial_clock_out))
        else $error("command moved off the falling edge");
    AST_SCLK_RATE: assert property (
        $rose(o_config_serial_clock_out)
        |-> ##2 !o_config_serial_clock_out [*2])
        else $error("serial clock too fast");
    AST_DONE_PINS: assert property (
        o_stage inside {3'h4, 3'h5, 3'h6} |-> !o_load_complete_oe
        && !o_config_serial_clock_oe && !o_select_output_low_oe
        && !o_serial_command_output_oe)
        else $error("pins still driven after load");
    AST_INIT_GATE: assert property (
        o_stage == 3'h5 && $past(o_stage) == 3'h4
        |-> $past(i_load_complete, 3))
        else $error("init began with load line low");
    AST_USER_IO: assert property (
        o_user_mode |-> o_stage == 3'h6 && o_core_reset_n
        && !o_user_io_tristate && !o_weak_pullup_en && !o_init_done_oe)
        else $error("user mode outputs wrong");
    AST_INIT_LEN: assert property (
        o_stage == 3'h6 && $past(o_stage) == 3'h5 && !i_user_clock_en
        |-> init_cnt_r >= TLO && init_cnt_r <= THI)
        else $error("init length wrong");
    AST_RECONF: assert property (
        !i_reconfig_req_n [*4] ##0 o_stage != 3'h0
        |=> o_stage == 3'h1 && o_status_line_oe && o_load_complete_oe)
        else $error("request did not reset");
    AST_HOLD_RESET: assert property (
        !i_status_line [*3] ##0 o_stage == 3'h1 |=> o_stage == 3'h1)
        else $error("left reset with status low");
    AST_ERR_LINES: assert property (
        o_stage == 3'h7 |-> o_status_line_oe && o_load_complete_oe
        && o_select_output_low_out && !o_config_serial_clock_out)
        else $error("error outputs wrong");
    AST_RESTART: assert property (
        o_stage == 3'h7 && i_auto_restart_en |-> int'(err_cnt_r) < RWIN)
        else $error("no timely restart");
endmodule // sfc_checker

bind sfc_config_master sfc_checker #(.RESTART_HOLD(RESTART_HOLD)) chk_inst (
    .i_clk_sys, .i_reset_n, .i_reconfig_req_n, .i_status_line,
    .i_load_complete, .i_auto_restart_en, .i_user_clock_en,
    .o_status_line_oe, .o_load_complete_oe, .o_config_serial_clock_out,
    .o_config_serial_clock_oe, .o_select_output_low_out,
    .o_select_output_low_oe, .o_serial_command_output_out,
    .o_serial_command_output_oe, .o_init_done_oe, .o_core_reset_n,
    .o_user_io_tristate, .o_weak_pullup_en, .o_user_mode, .o_stage
);

// [dv/sfc_testbench.sv]
`timescale 1ns/1ps
module testbench;
    import sfc_pkg::*;
    logic        i_clk_sys = 1'h0;
    logic        i_reset_n = 1'h0;
    logic [3:0]  i_scheme_select = 4'h4;
    logic        i_reconfig_req_n = 1'h1;
    logic        i_user_startup_clock = 1'h0;
    logic        i_user_clock_en = 1'h0;
    logic        i_auto_restart_en = 1'h0;
    logic        i_frame_error = 1'h0;
    logic [31:0] i_bitstream_bits = 32'h0;
    logic [31:0] pattern = 32'h0;
    logic [31:0] seed = 32'hC1423ADA;
    logic        ext_stat_low = 1'h0;
    logic        ext_load_low = 1'h0;
    logic        uclk_run = 1'h0;
    logic [7:0]  exp_q[$];
    logic [31:0] o_cmd_seen;
    int          failures = 0;
    int          check_count = 0;
    logic        o_status_line_out, o_status_line_oe, o_load_complete_out;
    logic        o_load_complete_oe, o_config_serial_clock_out;
    logic        o_config_serial_clock_oe, o_select_output_low_out;
    logic        o_select_output_low_oe, o_serial_command_output_out;
    logic        o_serial_command_output_oe, o_init_done_out, o_init_done_oe;
    logic        o_cfg_data_valid, o_core_reset_n, o_user_io_tristate;
    logic        o_weak_pullup_en, o_user_mode, i_flash_data;
    logic [7:0]  o_cfg_data;
    logic [2:0]  o_stage;
    // open-drain lines with external pull-ups
    wire logic i_status_line = ~(o_status_line_oe | ext_stat_low);
    wire logic i_load_complete = ~(o_load_complete_oe | ext_load_low);
    wire logic i_config_serial_clock =
        o_config_serial_clock_oe ? o_config_serial_clock_out : 1'h1;
    wire logic i_select_output_low =
        o_select_output_low_oe ? o_select_output_low_out : 1'h1;
    wire logic i_serial_command_output =
        o_serial_command_output_oe ? o_serial_command_output_out : 1'h1;

    sfc_config_master #(
        .POR_FAST_HOLD(24'h32),
        .POR_STD_HOLD (24'h50),
        .RESTART_HOLD (24'h28)
    ) sfc_config_master_inst (
        .i_clk_sys, .i_reset_n, .i_scheme_select, .i_reconfig_req_n,
        .i_status_line, .o_status_line_out, .o_status_line_oe,
        .i_load_complete, .o_load_complete_out, .o_load_complete_oe,
        .i_config_serial_clock, .o_config_serial_clock_out,
        .o_config_serial_clock_oe, .i_select_output_low,
        .o_select_output_low_out, .o_select_output_low_oe,
        .i_serial_command_output, .o_serial_command_output_out,
        .o_serial_command_output_oe, .i_flash_data, .i_user_startup_clock,
        .i_user_clock_en, .i_auto_restart_en, .i_frame_error,
        .i_bitstream_bits, .o_init_done_out, .o_init_done_oe, .o_cfg_data,
        .o_cfg_data_valid, .o_core_reset_n, .o_user_io_tristate,
        .o_weak_pullup_en, .o_user_mode, .o_stage
    );
    sfc_flash_model sfc_flash_model_inst (
        .i_sclk    (i_config_serial_clock),
        .i_sel_n   (i_select_output_low),
        .i_cmd     (i_serial_command_output),
        .i_pattern (pattern),
        .o_data    (i_flash_data),
        .o_cmd_seen
    );

    always #4 i_clk_sys = ~i_clk_sys;
    always #62.5 i_user_startup_clock = i_user_startup_clock ^ uclk_run;

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic stop_test();
        if (failures == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic wait_stage(logic [2:0] s, int lim);
        int n;
        n = 0;
        while (o_stage !== s && n < lim) begin
            @(posedge i_clk_sys);
            n++;
        end
        check("stage", o_stage, s);
    endtask

    task automatic cfg(logic [31:0] p, logic [31:0] nb);
        pattern <= p;
        i_bitstream_bits <= nb;
        exp_q.delete();
        for (int j = 0; j < nb / 8; j++)
            exp_q.push_back(p[31 - 8 * (j % 4) -: 8]);
    endtask

    task automatic por_len(int hold);
        int n;
        n = 0;
        check("tristate", o_user_io_tristate, 1);
        while (o_stage === 3'h0 && n < 1000) begin
            @(posedge i_clk_sys);
            n++;
        end
        check("por length", 32'(n >= hold - 2 && n <= hold + 6), 1);
    endtask

    task automatic por_run(logic [3:0] code, int hold);
        i_scheme_select <= code;
        i_reset_n <= 1'h0;
        repeat (3) @(posedge i_clk_sys);
        i_reset_n <= 1'h1;
        por_len(hold);
    endtask

    task automatic reconf();
        i_reconfig_req_n <= 1'h0;
        repeat (63) @(posedge i_clk_sys);
        check("reconfig", o_stage, 3'h1);
        i_reconfig_req_n <= 1'h1;
    endtask

    task automatic err_pulse();
        wait_stage(3'h3, 400);
        repeat (40) @(posedge i_clk_sys);
        i_frame_error <= 1'h1;
        @(posedge i_clk_sys);
        i_frame_error <= 1'h0;
        wait_stage(3'h7, 4);
    endtask

    always @(posedge i_clk_sys) begin
        if (i_reset_n && o_cfg_data_valid === 1'h1) begin
            if (exp_q.size() == 0)
                check("byte count", 1, 0);
            else
                check("byte", o_cfg_data, exp_q.pop_front());
        end
    end

    initial begin
        repeat (100000) @(posedge i_clk_sys);
        failures++;
        $display("mismatch watchdog expected finish seen hang");
        stop_test();
    end

    initial begin
        repeat (12) @(posedge i_clk_sys);
        cfg(rnd() | 32'h80000000, 32'(8 * (2 + rnd() % 3) + 3));
        ext_load_low <= 1'h1;
        i_reset_n <= 1'h1;
        por_len(50);
        check("drive low", {o_status_line_out, o_load_complete_out,
                            o_init_done_out}, 0);
        wait_stage(3'h2, 10);
        wait_stage(3'h4, 4 * i_bitstream_bits + 200);
        check("command", o_cmd_seen, {FLASH_READ_CMD, FLASH_START_ADR});
        check("init done", o_init_done_oe, 1);
        repeat (20) @(posedge i_clk_sys);
        check("wait load", o_stage, 3'h4);
        ext_load_low <= 1'h0;
        wait_stage(3'h5, 8);
        wait_stage(3'h6, 3186 * 13);
        check("bytes left", exp_q.size(), 0);
        check("pull-ups", o_weak_pullup_en, 0);
        reconf();
        ext_stat_low <= 1'h1;
        cfg(rnd() & 32'h7FFFFFFF, 32'h100);
        repeat (10) @(posedge i_clk_sys);
        check("status low", o_stage, 3'h1);
        ext_stat_low <= 1'h0;
        err_pulse();
        repeat (100) @(posedge i_clk_sys);
        check("no restart", o_stage, 3'h7);
        i_auto_restart_en <= 1'h1;
        reconf();
        cfg(pattern, i_bitstream_bits);
        err_pulse();
        wait_stage(3'h1, 60);
        cfg(pattern, i_bitstream_bits);
        i_user_clock_en <= 1'h1;
        uclk_run <= 1'h1;
        wait_stage(3'h4, 1400);
        uclk_run <= 1'h0;
        check("init done", o_init_done_oe, 0);
        wait_stage(3'h5, 8);
        repeat (2000) @(posedge i_clk_sys);
        check("held init", o_stage, 3'h5);
        uclk_run <= 1'h1;
        wait_stage(3'h6, 3185 * 16 + 200);
        check("bytes left", exp_q.size(), 0);
        por_run(4'hD, 50);
        por_run(4'h2, 80);
        stop_test();
    end
endmodule // testbench
